// ==== hw/tamper_guard.sv ====
// Tamper and waveform guard with its retained backup data bank.
// Assumes pins are asynchronous and control ports are on clk_sys_in.
// Operation
// - Two tamper pins and two wave checks.
// - Forty-two 16-bit retained backup words.
// - System reset never touches backup words.
// - Software picks each tamper pin active level.
// - Each pin detects only with own enable.
// - Detected edge ANDed with enable bit.
// - Tamper event sets that source's flag.
// - Flag set with enable raises interrupt.
// - Any tamper event wipes all backup words.
// - Enabled check drives a square wave out; only check one if both.
// - Looped-back wave received and compared.
// - Wave mismatch sets second tamper flag.
// - Events route to interrupt or event.
// - Calibration selects alarm/second, holds value.
`timescale 1ns/1ps
`include "guard_consts.svh"
module tamper_guard #(
	parameter int WAVE_HALF = `WAVE_HALF_CYC,
	parameter int SETTLE = `WAVE_SETTLE_CYC
) (
	// Clock and reset.
	input wire logic clk_sys_in,
	input wire logic rst_n_in,
	// Tamper pin inputs, first and second.
	input wire logic tamper_pin_a_in,
	input wire logic tamper_pin_b_in,
	// First tamper pin output drive for wave check one.
	output logic tamper_pin_a_out,
	output logic tamper_pin_a_oe_out,
	// Low-speed oscillator pins for wave check two.
	output logic osc_pin_a_out,
	output logic osc_pin_a_oe_out,
	input wire logic osc_pin_b_in,
	// Tamper control bits, per pin.
	input wire logic intrusion_detect_en_a_in,
	input wire logic intrusion_detect_en_b_in,
	input wire logic active_low_a_in,
	input wire logic active_low_b_in,
	input wire logic wave_check_en_a_in,
	input wire logic wave_check_en_b_in,
	// Interrupt and event routing bits.
	input wire logic irq_en_in,
	input wire logic event_en_in,
	input wire logic wave_irq_en_in,
	input wire logic wave_event_en_in,
	// One-cycle clear strobes for the flags.
	input wire logic flag_clear_a_in,
	input wire logic flag_clear_b_in,
	// Calibration settings.
	input wire guard_pkg::cal_out_sel_t cal_sel_in,
	input wire logic [`CAL_WIDTH-1:0] cal_value_in,
	input wire logic cal_out_en_in,
	input wire logic rtc_alarm_in,
	input wire logic rtc_second_in,
	// Backup word access.
	input wire logic bkp_wr_in,
	input wire guard_pkg::backup_addr_t bkp_addr_in,
	input wire guard_pkg::backup_word_t bkp_wdata_in,
	output guard_pkg::backup_word_t bkp_rdata_out,
	// Status and requests.
	output logic intrusion_flag_a_out,
	output logic intrusion_flag_b_out,
	output logic irq_out,
	output logic event_out,
	output logic rtc_pin_out,
	output logic [`CAL_WIDTH-1:0] cal_value_out
);
	import guard_pkg::*;

	// Released reset copy.
	logic [1:0] rst_sync_q;
	logic rst_n;
	// Three-stage synchronisers for tamper and return pins.
	logic [2:0] pin_a_q;
	logic [2:0] pin_b_q;
	logic [2:0] osc_b_q;
	// Debounced pin levels accepted when stages two and three agree.
	logic pin_a_lvl_q;
	logic pin_b_lvl_q;
	logic osc_b_lvl_q;
	// Active states of the tamper pins after polarity.
	logic act_a;
	logic act_b;
	logic act_a_prev_q;
	logic act_b_prev_q;
	// Qualified detection pulses.
	logic det_a;
	logic det_b;
	// Wave generator state.
	logic [15:0] wave_cnt_q;
	logic wave_q;
	logic [7:0] settle_q;
	logic wave_fail;
	logic wave_ret;
	logic wave_on;
	// Whether a wave failure set flag b, for routing.
	logic wave_src_q;
	// Sticky flags.
	logic flag_a_q;
	logic flag_b_q;
	// Delayed copies for event pulses.
	logic flag_a_prev_q;
	logic flag_b_prev_q;
	logic event_q;
	logic rtc_pin_q;
	logic [`CAL_WIDTH-1:0] cal_q;

	// Bank connection.
	backup_bank_if bank_if ();

	// Reset released through two flip-flops.
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rst_sync_q <= 2'h0;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_q[1];

	// Pin synchronisers; stage one feeds only stage two.
	always_ff @(posedge clk_sys_in or negedge rst_n) begin
		if (!rst_n) begin
			pin_a_q <= 3'h0;
			pin_b_q <= 3'h0;
			osc_b_q <= 3'h0;
		end else begin
			pin_a_q <= {pin_a_q[1:0], tamper_pin_a_in};
			pin_b_q <= {pin_b_q[1:0], tamper_pin_b_in};
			osc_b_q <= {osc_b_q[1:0], osc_pin_b_in};
		end
	end

	// A level is taken once the second and third stages agree.
	always_ff @(posedge clk_sys_in or negedge rst_n) begin
		if (!rst_n) begin
			pin_a_lvl_q <= 1'b0;
			pin_b_lvl_q <= 1'b0;
			osc_b_lvl_q <= 1'b0;
		end else begin
			if (pin_a_q[1] == pin_a_q[2]) begin
				pin_a_lvl_q <= pin_a_q[2];
			end
			if (pin_b_q[1] == pin_b_q[2]) begin
				pin_b_lvl_q <= pin_b_q[2];
			end
			if (osc_b_q[1] == osc_b_q[2]) begin
				osc_b_lvl_q <= osc_b_q[2];
			end
		end
	end

	// Polarity per pin; both pins are ignored while check one sends a wave.
	assign act_a = (pin_a_lvl_q ^ active_low_a_in) && !wave_check_en_a_in;
	assign act_b = (pin_b_lvl_q ^ active_low_b_in) && !wave_check_en_a_in;

	// Previous active states for edge detection.
	// They rest high in reset, so that a pin which reads active while the
	// synchroniser is still filling gives no false tamper edge.
	always_ff @(posedge clk_sys_in or negedge rst_n) begin
		if (!rst_n) begin
			act_a_prev_q <= 1'b1;
			act_b_prev_q <= 1'b1;
		end else begin
			act_a_prev_q <= act_a;
			act_b_prev_q <= act_b;
		end
	end

	// Edge into the active level, qualified by each pin's own enable.
	assign det_a = act_a && !act_a_prev_q && intrusion_detect_en_a_in;
	assign det_b = act_b && !act_b_prev_q && intrusion_detect_en_b_in;

	// Check one has priority over check two when both are enabled.
	assign wave_on = wave_check_en_a_in || wave_check_en_b_in;

	// Square wave generator with a settle count after each edge.
	always_ff @(posedge clk_sys_in or negedge rst_n) begin
		if (!rst_n) begin
			wave_cnt_q <= 16'h0000;
			wave_q <= 1'b0;
			settle_q <= 8'h00;
		end else if (!wave_on) begin
			wave_cnt_q <= 16'h0000;
			wave_q <= 1'b0;
			settle_q <= 8'(SETTLE);
		end else if (wave_cnt_q == 16'(WAVE_HALF - 1)) begin
			wave_cnt_q <= 16'h0000;
			wave_q <= !wave_q;
			settle_q <= 8'(SETTLE);
		end else begin
			wave_cnt_q <= wave_cnt_q + 16'h0001;
			if (settle_q != 8'h00) begin
				settle_q <= settle_q - 8'h01;
			end
		end
	end

	// Return path: second tamper pin for check one, oscillator pin for two.
	assign wave_ret = wave_check_en_a_in ? pin_b_lvl_q : osc_b_lvl_q;
	// Mismatch once the return has had time to settle.
	assign wave_fail = wave_on && (settle_q == 8'h00)
		&& (wave_ret != wave_q);

	// Remember that a wave check, not pin b, set flag b, for routing its request.
	always_ff @(posedge clk_sys_in or negedge rst_n) begin
		if (!rst_n) begin
			wave_src_q <= 1'b0;
		end else if (wave_fail) begin
			wave_src_q <= 1'b1;
		end else if (flag_clear_b_in) begin
			wave_src_q <= 1'b0;
		end
	end

	// Sticky flags: a set in the clear cycle wins.
	always_ff @(posedge clk_sys_in or negedge rst_n) begin
		if (!rst_n) begin
			flag_a_q <= 1'b0;
			flag_b_q <= 1'b0;
		end else begin
			if (det_a) begin
				flag_a_q <= 1'b1;
			end else if (flag_clear_a_in) begin
				flag_a_q <= 1'b0;
			end
			if (det_b || wave_fail) begin
				flag_b_q <= 1'b1;
			end else if (flag_clear_b_in) begin
				flag_b_q <= 1'b0;
			end
		end
	end

	// Previous flag states, for one-cycle event pulses.
	always_ff @(posedge clk_sys_in or negedge rst_n) begin
		if (!rst_n) begin
			flag_a_prev_q <= 1'b0;
			flag_b_prev_q <= 1'b0;
		end else begin
			flag_a_prev_q <= flag_a_q;
			flag_b_prev_q <= flag_b_q;
		end
	end

	// Interrupt held while a flag and its enable are both set.
	assign irq_out = (irq_en_in && (flag_a_q || (flag_b_q && !wave_src_q)))
		|| (wave_irq_en_in && flag_b_q && wave_src_q);

	// Event output pulses one cycle when a routed flag rises.
	always_ff @(posedge clk_sys_in or negedge rst_n) begin
		if (!rst_n) begin
			event_q <= 1'b0;
		end else begin
			event_q <= (event_en_in && ((flag_a_q && !flag_a_prev_q)
				|| (flag_b_q && !flag_b_prev_q && !wave_src_q)))
				|| (wave_event_en_in && flag_b_q && !flag_b_prev_q
				&& wave_src_q);
		end
	end
	assign event_out = event_q;

	// Calendar output pin and held calibration value.
	always_ff @(posedge clk_sys_in or negedge rst_n) begin
		if (!rst_n) begin
			rtc_pin_q <= 1'b0;
			cal_q <= '0;
		end else begin
			rtc_pin_q <= cal_out_en_in && ((cal_sel_in == CAL_OUT_SECOND)
				? rtc_second_in : rtc_alarm_in);
			cal_q <= cal_value_in;
		end
	end
	assign rtc_pin_out = rtc_pin_q;
	assign cal_value_out = cal_q;

	// Wave drive onto the pins.
	assign tamper_pin_a_out = wave_q && wave_check_en_a_in;
	assign tamper_pin_a_oe_out = wave_check_en_a_in;
	assign osc_pin_a_out = wave_q && !wave_check_en_a_in
		&& wave_check_en_b_in;
	assign osc_pin_a_oe_out = wave_check_en_b_in && !wave_check_en_a_in;

	// Bank requests; any tamper event wipes every word.
	assign bank_if.wipe = det_a || det_b || wave_fail;
	assign bank_if.wr_en = bkp_wr_in;
	assign bank_if.addr = bkp_addr_in;
	assign bank_if.wr_data = bkp_wdata_in;
	assign bkp_rdata_out = bank_if.rd_data;

	// Retained bank with no reset input at all.
	backup_bank #(
		.WORDS(`BACKUP_WORDS)
	) u_bank (
		.clk_sys_in(clk_sys_in),
		.bus(bank_if.bank)
	);

	assign intrusion_flag_a_out = flag_a_q;
	assign intrusion_flag_b_out = flag_b_q;
endmodule // tamper_guard

// ==== pkg/guard_consts.svh ====
// Constants for the tamper and waveform guard: sizes, reset values, timing.
// Assumes nothing; included by the package and the design files.
`ifndef GUARD_CONSTS_SVH
`define GUARD_CONSTS_SVH
// Number of backup data words kept in the retained bank.
`define BACKUP_WORDS 42
// Width of one backup data word.
`define BACKUP_WIDTH 16
// Address width of the backup bank.
`define BACKUP_AW 6
// Reset value of a cleared backup word.
`define BACKUP_CLEAR 16'h0000
// Half period of the check square wave in ns.
`define WAVE_HALF_NS 5000
// Clock period in ns.
`define CLK_PERIOD_NS 5
// Half period of the check square wave in clock cycles.
`define WAVE_HALF_CYC (`WAVE_HALF_NS / `CLK_PERIOD_NS)
// Cycles after an edge of the sent wave before the return is sampled.
`define WAVE_SETTLE_CYC 16
// Width of the calibration value.
`define CAL_WIDTH 7
`endif

// ==== pkg/guard_pkg.sv ====
// Types shared by the guard design files.
// Assumes the constants header sits beside it.
`include "guard_consts.svh"
package guard_pkg;
	// Backup word type.
	typedef logic [`BACKUP_WIDTH-1:0] backup_word_t;
	// Backup address type.
	typedef logic [`BACKUP_AW-1:0] backup_addr_t;
	// Selection for the calendar output pin.
	typedef enum logic {
		CAL_OUT_ALARM,
		CAL_OUT_SECOND
	} cal_out_sel_t;
endpackage

// ==== pkg/backup_bank_if.sv ====
// Interface between the guard and its retained backup bank.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ps
interface backup_bank_if;
	import guard_pkg::*;
	// Write strobe for one word.
	logic wr_en;
	// Word address for read and write.
	backup_addr_t addr;
	// Write data.
	backup_word_t wr_data;
	// Read data, registered in the bank.
	backup_word_t rd_data;
	// Wipe every word; overrides a write.
	logic wipe;
	// Guard drives requests, bank answers with data.
	modport guard (output wr_en, output addr, output wr_data, output wipe,
		input rd_data);
	modport bank (input wr_en, input addr, input wr_data, input wipe,
		output rd_data);
endinterface

// ==== hw/backup_bank.sv ====
// Retained bank of backup data words with one-cycle registered read.
// Assumes it has no reset of its own so that system reset leaves it intact.
`timescale 1ns/1ps
`include "guard_consts.svh"
module backup_bank #(
	parameter int WORDS = `BACKUP_WORDS
) (
	// Clock.
	input wire logic clk_sys_in,
	// Bank port.
	backup_bank_if.bank bus
);
	import guard_pkg::*;
	// Storage array; only a wipe or a write changes it.
	backup_word_t mem_q [WORDS];
	// Registered read data.
	backup_word_t rd_q;

	// Each word takes the wipe, else a write aimed at it.
	for (genvar i = 0; i < WORDS; i++) begin : g_word
		always_ff @(posedge clk_sys_in) begin
			if (bus.wipe) begin
				mem_q[i] <= `BACKUP_CLEAR;
			end else if (bus.wr_en && (bus.addr == backup_addr_t'(i))) begin
				mem_q[i] <= bus.wr_data;
			end
		end
	end

	// Read data come from a register; out-of-range addresses read zero.
	always_ff @(posedge clk_sys_in) begin
		if (int'(bus.addr) < WORDS) begin
			rd_q <= mem_q[bus.addr];
		end else begin
			rd_q <= `BACKUP_CLEAR;
		end
	end

	assign bus.rd_data = rd_q;
endmodule // backup_bank

// ==== testbench/guard_asserts.sv ====
// Port checker for the tamper guard.
// Assumes one clock domain; bound to the guard after the module.
`timescale 1ns/1ps
`include "guard_consts.svh"
module guard_asserts (
	// Clock and reset.
	input wire logic clk_sys_in,
	input wire logic rst_n_in,
	// Control inputs.
	input wire logic wave_check_en_a_in,
	input wire logic irq_en_in,
	input wire logic event_en_in,
	input wire logic flag_clear_a_in,
	input wire logic flag_clear_b_in,
	input wire logic [`CAL_WIDTH-1:0] cal_value_in,
	input wire logic bkp_wr_in,
	input wire guard_pkg::backup_addr_t bkp_addr_in,
	input wire guard_pkg::backup_word_t bkp_wdata_in,
	// Outputs.
	input wire guard_pkg::backup_word_t bkp_rdata_out,
	input wire logic tamper_pin_a_oe_out,
	input wire logic osc_pin_a_oe_out,
	input wire logic intrusion_flag_a_out,
	input wire logic intrusion_flag_b_out,
	input wire logic irq_out,
	input wire logic event_out,
	input wire logic [`CAL_WIDTH-1:0] cal_value_out
);
	import guard_pkg::*;
	default clocking cb @(posedge clk_sys_in);
	endclocking
	default disable iff (!rst_n_in);
	// A write, then a quiet cycle on the same word.
	sequence s_wr;
		(bkp_wr_in && bkp_addr_in < `BACKUP_WORDS)
		##1 (!bkp_wr_in && $stable(bkp_addr_in));
	endsequence
	// Either flag rising marks a tamper event.
	sequence s_evt;
		$rose(intrusion_flag_a_out) || $rose(intrusion_flag_b_out);
	endsequence
	AST_BANK_RD: assert property (
		s_wr |=> bkp_rdata_out == $past(bkp_wdata_in, 2))
		else $error("backup word lost");
	AST_UNMAPPED: assert property (
		bkp_addr_in >= `BACKUP_WORDS |=> bkp_rdata_out == '0)
		else $error("unmapped word not zero");
	AST_WIPE: assert property (s_evt |-> ##[1:2] bkp_rdata_out == '0)
		else $error("bank not wiped");
	AST_STICKY_A: assert property (
		intrusion_flag_a_out && !flag_clear_a_in |=> intrusion_flag_a_out)
		else $error("flag a dropped");
	AST_STICKY_B: assert property (
		intrusion_flag_b_out && !flag_clear_b_in |=> intrusion_flag_b_out)
		else $error("flag b dropped");
	AST_IRQ: assert property (intrusion_flag_a_out && irq_en_in |-> irq_out)
		else $error("no interrupt");
	AST_EVENT: assert property (
		$rose(intrusion_flag_a_out) && event_en_in |-> ##[0:2] event_out)
		else $error("no event pulse");
	AST_WAVE_OE: assert property (
		wave_check_en_a_in [*2] |-> tamper_pin_a_oe_out && !osc_pin_a_oe_out)
		else $error("wave drive wrong");
	AST_CAL: assert property (
		$stable(cal_value_in) [*2] |-> cal_value_out == cal_value_in)
		else $error("calibration not held");
endmodule // guard_asserts
bind tamper_guard guard_asserts guard_asserts_inst (.*);

// ==== testbench/loop_wire.sv ====
// Far side of the guard: tamper switches and the loop-back wire.
// Assumes the bench sets switch levels and the break command.
`timescale 1ns/1ps
module loop_wire (
	// Clock for the idle pattern.
	input wire logic clk_sys_in,
	// Guard drive and bench commands.
	input wire logic tamper_pin_a_out,
	input wire logic tamper_pin_a_oe_out,
	input wire logic osc_pin_a_out,
	input wire logic osc_pin_a_oe_out,
	input wire logic sw_a_in,
	input wire logic sw_b_in,
	input wire logic break_in,
	// Levels seen by the guard.
	output logic tamper_pin_a_in,
	output logic tamper_pin_b_in,
	output logic osc_pin_b_in
);
	// A released oscillator line has no pull, so it wanders.
	logic idle_q = 1'h0;
	always @(posedge clk_sys_in) begin
		idle_q <= !idle_q;
	end
	// The guard's own drive wins over the switch.
	assign tamper_pin_a_in = tamper_pin_a_oe_out ? tamper_pin_a_out : sw_a_in;
	// The wire returns the wave, inverted when broken.
	assign tamper_pin_b_in = tamper_pin_a_oe_out ?
		tamper_pin_a_out ^ break_in : sw_b_in;
	assign osc_pin_b_in = osc_pin_a_oe_out ? osc_pin_a_out ^ break_in : idle_q;
endmodule // loop_wire

// ==== testbench/tb_top.sv ====
// Self-checking bench for the tamper guard.
// Assumes the guard, its bank and the loop wire are compiled first.
`timescale 1ns/1ps
module tb_top;
	import guard_pkg::*;
	// Inputs, all given a value at time zero.
	logic clk_sys_in = 1'h0, rst_n_in = 1'h0;
	logic intrusion_detect_en_a_in = 1'h0, intrusion_detect_en_b_in = 1'h0;
	logic active_low_a_in = 1'h0, active_low_b_in = 1'h0;
	logic wave_check_en_a_in = 1'h0, wave_check_en_b_in = 1'h0;
	logic irq_en_in = 1'h0, event_en_in = 1'h0;
	logic wave_irq_en_in = 1'h0, wave_event_en_in = 1'h0;
	logic flag_clear_a_in = 1'h0, flag_clear_b_in = 1'h0;
	cal_out_sel_t cal_sel_in = CAL_OUT_ALARM;
	logic [6:0] cal_value_in = 7'h00;
	logic cal_out_en_in = 1'h0, rtc_alarm_in = 1'h0, rtc_second_in = 1'h0;
	logic bkp_wr_in = 1'h0;
	backup_addr_t bkp_addr_in = 6'h00;
	backup_word_t bkp_wdata_in = 16'h0000;
	logic sw_a_in = 1'h1, sw_b_in = 1'h0, break_in = 1'h0;
	// Outputs and pin levels.
	wire logic tamper_pin_a_in, tamper_pin_b_in, osc_pin_b_in;
	logic tamper_pin_a_out, tamper_pin_a_oe_out, osc_pin_a_out;
	logic osc_pin_a_oe_out, intrusion_flag_a_out, intrusion_flag_b_out;
	logic irq_out, event_out, rtc_pin_out, mon_q;
	logic [6:0] cal_value_out;
	backup_word_t bkp_rdata_out;
	int num_errors = 0, checked = 0, cyc = 0, toggles = 0, ev_cnt = 0;
	tamper_guard #(.WAVE_HALF(8), .SETTLE(6)) tamper_guard_inst (.*);
	loop_wire loop_wire_inst (.*);
	always #2.5 clk_sys_in = ~clk_sys_in;
	// Catch event pulses and count edges of the sent wave.
	always @(posedge clk_sys_in) begin
		if (event_out === 1'h1) ev_cnt++;
		mon_q <= wave_check_en_b_in ? osc_pin_a_out : tamper_pin_a_out;
		if (mon_q !== (wave_check_en_b_in ? osc_pin_a_out : tamper_pin_a_out))
			toggles++;
		cyc++;
		if (cyc == 4000) begin
			num_errors++;
			give_verdict;
		end
	end
	task automatic tick;
		@(posedge clk_sys_in);
	endtask
	// Waits n cycles and stops where outputs are settled.
	task automatic wt(input int n);
		repeat (n) @(negedge clk_sys_in);
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value at %0t: %h, not %h", $time, got, exp);
		end
	endtask
	task automatic wr(input backup_addr_t a, input backup_word_t d);
		tick;
		bkp_wr_in <= 1'h1;
		bkp_addr_in <= a;
		bkp_wdata_in <= d;
		tick;
		bkp_wr_in <= 1'h0;
	endtask
	task automatic rd(input backup_addr_t a, input backup_word_t d);
		tick;
		bkp_addr_in <= a;
		wt(2);
		chk(bkp_rdata_out, d);
	endtask
	// Pulses both clear strobes; flags must drop and stay low.
	task automatic clr;
		tick;
		flag_clear_a_in <= 1'h1;
		flag_clear_b_in <= 1'h1;
		tick;
		flag_clear_a_in <= 1'h0;
		flag_clear_b_in <= 1'h0;
		wt(3);
		chk({intrusion_flag_a_out, intrusion_flag_b_out}, 2'h0);
	endtask
	task automatic t_bank;
		wr(6'h00, 16'ha5c3);
		wr(6'h29, 16'h5a3c);
		rd(6'h00, 16'ha5c3);
		rd(6'h29, 16'h5a3c);
		rd(6'h2a, 16'h0000);
		tick;
		rst_n_in <= 1'h0;
		wt(3);
		tick;
		rst_n_in <= 1'h1;
		wt(4);
		rd(6'h29, 16'h5a3c);
		$display("bank test end");
	endtask
	task automatic t_pin_a;
		int ev0;
		ev0 = ev_cnt;
		tick;
		active_low_a_in <= 1'h1;
		irq_en_in <= 1'h1;
		event_en_in <= 1'h1;
		sw_a_in <= 1'h0;
		wt(10);
		chk(intrusion_flag_a_out, 1'h0);
		tick;
		sw_a_in <= 1'h1;
		wt(6);
		tick;
		intrusion_detect_en_a_in <= 1'h1;
		wt(8);
		chk(intrusion_flag_a_out, 1'h0);
		tick;
		sw_a_in <= 1'h0;
		wt(10);
		chk(intrusion_flag_a_out, 1'h1);
		chk(irq_out, 1'h1);
		chk(16'(ev_cnt - ev0), 16'h0001);
		rd(6'h29, 16'h0000);
		clr;
		chk(irq_out, 1'h0);
		tick;
		sw_a_in <= 1'h1;
		intrusion_detect_en_a_in <= 1'h0;
		irq_en_in <= 1'h0;
		event_en_in <= 1'h0;
		$display("pin a test end");
	endtask
	task automatic t_pin_b;
		int ev0;
		ev0 = ev_cnt;
		tick;
		intrusion_detect_en_b_in <= 1'h1;
		wt(6);
		tick;
		sw_b_in <= 1'h1;
		wt(10);
		chk({intrusion_flag_a_out, intrusion_flag_b_out}, 2'h1);
		chk({irq_out, ev_cnt != ev0}, 2'h0);
		clr;
		// Same pin, now active low: the high idle level must not trip it.
		tick;
		intrusion_detect_en_b_in <= 1'h0;
		active_low_b_in <= 1'h1;
		wt(6);
		tick;
		intrusion_detect_en_b_in <= 1'h1;
		wt(4);
		chk(intrusion_flag_b_out, 1'h0);
		tick;
		sw_b_in <= 1'h0;
		wt(10);
		chk(intrusion_flag_b_out, 1'h1);
		clr;
		tick;
		active_low_b_in <= 1'h0;
		intrusion_detect_en_b_in <= 1'h0;
		$display("pin b test end");
	endtask
	task automatic t_wave(input logic b);
		int tg0, ev0;
		wr(6'h05, 16'h1234);
		tick;
		wave_irq_en_in <= 1'h1;
		wave_event_en_in <= b;
		wave_check_en_a_in <= !b;
		wave_check_en_b_in <= b;
		tg0 = toggles;
		ev0 = ev_cnt;
		wt(64);
		chk(intrusion_flag_b_out, 1'h0);
		chk(toggles - tg0 >= 6, 1'h1);
		rd(6'h05, 16'h1234);
		tick;
		break_in <= 1'h1;
		wt(40);
		chk({intrusion_flag_b_out, irq_out}, 2'h3);
		chk(16'(ev_cnt - ev0), 16'(b));
		rd(6'h05, 16'h0000);
		tick;
		break_in <= 1'h0;
		wave_check_en_a_in <= 1'h0;
		wave_check_en_b_in <= 1'h0;
		wave_irq_en_in <= 1'h0;
		wave_event_en_in <= 1'h0;
		wt(4);
		clr;
		$display("wave test end");
	endtask
	task automatic t_cal;
		tick;
		cal_value_in <= 7'h5a;
		cal_sel_in <= CAL_OUT_SECOND;
		cal_out_en_in <= 1'h1;
		rtc_second_in <= 1'h1;
		wt(3);
		chk({cal_value_out, rtc_pin_out}, 8'hb5);
		tick;
		cal_sel_in <= CAL_OUT_ALARM;
		wt(3);
		chk(rtc_pin_out, 1'h0);
		$display("calibration test end");
	endtask
	task automatic give_verdict;
		$display("mismatches %0d of %0d checks", num_errors, checked);
		if (num_errors == 0 && checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	// Reset for twelve cycles, then run every scenario.
	initial begin
		wt(12);
		tick;
		rst_n_in <= 1'h1;
		wt(4);
		t_bank;
		t_pin_a;
		t_pin_b;
		t_wave(1'h0);
		t_wave(1'h1);
		t_cal;
		give_verdict;
	end
endmodule // tb_top
